// ==== inc/tarith_pkg.sv ====
package tarith_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_INSTR     = 8'h00;
	localparam logic [7:0] OFS_OPERAND   = 8'h04;
	localparam logic [7:0] OFS_FLAGS     = 8'h08;
	localparam logic [7:0] OFS_STACK     = 8'h0c;
	localparam logic [7:0] OFS_MODE      = 8'h10;
	localparam logic [7:0] OFS_PC        = 8'h14;
	localparam logic [7:0] OFS_TRAP_FLAGS = 8'h18;
	localparam logic [7:0] OFS_TRAP_PC   = 8'h1c;
	localparam logic [7:0] OFS_STATUS    = 8'h20;

	// Flag positions inside the flag and control word
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;

	// Status register field positions
	localparam int ST_BUSY      = 0;
	localparam int ST_TRAPPED   = 1;
	localparam int ST_ILLEGAL   = 2;
	localparam int ST_TEST_DONE = 3;
	localparam int ST_CAUSE_LSB = 4;
	localparam int ST_EXT_LSB   = 8;
	localparam int ST_PTR_LONG  = 10;

	// Reset values
	localparam logic [15:0] RST_FLAGS = 16'h0000;
	localparam logic [31:0] RST_STACK = 32'h0000_0000;
	localparam logic [31:0] RST_PC   = 32'h0000_0000;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Address representation modes
	localparam logic [1:0] MODE_COMPACT   = 2'h0;
	localparam logic [1:0] MODE_SEGMENTED = 2'h1;
	localparam logic [1:0] MODE_LINEAR    = 2'h2;

	// Opcode fields
	localparam logic [3:0] ZCMP_NIBBLE   = 4'hc;
	localparam logic [6:0] ZCMP_REG_HI   = 7'b1000110;
	localparam logic [6:0] ZCMP_IR_HI    = 7'b0000110;
	localparam logic [6:0] ZCMP_EAM_HI   = 7'b0100110;
	localparam logic [7:0] ZCMP_REG_L    = 8'b1001_1100;
	localparam logic [7:0] ZCMP_IR_L     = 8'b0001_1100;
	localparam logic [7:0] ZCMP_EAM_L    = 8'b0101_1100;
	localparam logic [7:0] TRAP_OPCODE   = 8'h7e;

	// Stack decrements in bytes
	localparam logic [31:0] STATUS_BYTES = 32'h0000_0006;
	localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_e;

endpackage

// ==== logic/test_arith_and_cond_trap.sv ====
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module test_arith_and_cond_trap
	import tarith_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output logic             stack_we,
	output logic [31:0]      stack_addr,
	output logic [47:0]      stack_wdata,
	output logic [2:0]       stack_nbytes,
	output logic             trap_event,
	output logic [3:0]       trap_cause,
	output logic [3:0]       ptr_reg,
	output logic             ptr_long
);

	typedef enum logic [2:0] {S_IDLE, S_EXEC, S_PUSH_STATUS, S_PUSH_INSTR, S_LOAD_STATUS} state_e;

	state_e      state;
	logic [15:0] instr;
	logic [31:0] operand;
	logic [15:0] flag_control_word;
	logic [31:0] system_stack_pointer;
	logic [1:0]  addr_mode;
	logic [31:0] pc;
	logic [15:0] trap_flags;
	logic [31:0] trap_pc;
	logic        st_trapped;
	logic        st_illegal;
	logic        st_test_done;
	logic [1:0]  st_ext;

	// Decode results
	logic        is_zcmp;
	logic        is_trap;
	logic        form_ir;
	logic        form_eam;
	size_e       op_size;
	logic [1:0]  ext_words;
	logic        cond_ok;
	logic        bad_ptr;
	logic [31:0] masked;
	logic        neg;

	// Bus access phase and register hits
	logic acc;
	logic wr_ok;
	logic mapped;

	assign acc = psel & penable & pready;
	// Writes only land while idle, so hardware updates never race software
	assign wr_ok = acc & pwrite & (state == S_IDLE) & mapped & (paddr != OFS_STATUS);

	always_comb begin
		unique case (paddr)
			OFS_INSTR, OFS_OPERAND, OFS_FLAGS, OFS_STACK, OFS_MODE,
			OFS_PC, OFS_TRAP_FLAGS, OFS_TRAP_PC, OFS_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Condition evaluation against the current flags
	function automatic logic cond_eval(input logic [3:0] condition_field, input logic [15:0] f);
		logic c;
		logic z;
		logic s;
		logic v;
		logic r;
		c = f[FLAG_C];
		z = f[FLAG_Z];
		s = f[FLAG_S];
		v = f[FLAG_V];
		unique case (condition_field[2:0])
			3'h0: r = 1'b0;
			3'h1: r = s ^ v;
			3'h2: r = z | (s ^ v);
			3'h3: r = c | z;
			3'h4: r = v;
			3'h5: r = s;
			3'h6: r = z;
			3'h7: r = c;
		endcase
		return condition_field[3] ? ~r : r;
	endfunction

	// Instruction decode
	always_comb begin
		is_zcmp   = 1'b0;
		form_ir   = 1'b0;
		form_eam  = 1'b0;
		op_size   = instr[8] ? SZ_WORD : SZ_BYTE;
		if (instr[3:0] == ZCMP_NIBBLE) begin
			if (instr[15:9] == ZCMP_REG_HI || instr[15:9] == ZCMP_IR_HI
					|| instr[15:9] == ZCMP_EAM_HI) begin
				is_zcmp = 1'b1;
			end else if (instr[15:8] == ZCMP_REG_L || instr[15:8] == ZCMP_IR_L
					|| instr[15:8] == ZCMP_EAM_L) begin
				is_zcmp = 1'b1;
				op_size  = SZ_LONG;
			end
			form_ir  = (instr[15:14] == 2'b00);
			form_eam = (instr[15:14] == 2'b01);
		end
		is_trap   = (instr[15:8] == TRAP_OPCODE);
		// Extended forms carry one to three extension words
		ext_words = (form_eam && is_zcmp) ? ((instr[5:4] == 2'h0) ? 2'h1 : instr[5:4]) : 2'h0;
		bad_ptr   = is_zcmp & form_ir & (instr[7:4] == 4'h0);
		cond_ok   = cond_eval(instr[3:0], flag_control_word);
	end

	// Operand minus zero: result equals operand, sized for flag purposes
	always_comb begin
		unique case (op_size)
			SZ_BYTE: begin
				masked = {24'h000000, operand[7:0]};
				neg    = operand[7];
			end
			SZ_WORD: begin
				masked = {16'h0000, operand[15:0]};
				neg    = operand[15];
			end
			default: begin
				masked = operand;
				neg    = operand[31];
			end
		endcase
	end

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: if (wr_ok && paddr == OFS_INSTR) state <= S_EXEC;
				S_EXEC: begin
					if (is_trap && cond_ok) begin
						state <= S_PUSH_STATUS;
					end else begin
						state <= S_IDLE;
					end
				end
				S_PUSH_STATUS: state <= S_PUSH_INSTR;
				S_PUSH_INSTR:  state <= S_LOAD_STATUS;
				S_LOAD_STATUS: state <= S_IDLE;
			endcase
		end
	end

	// Instruction, operand and software-only settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr     <= RST_WORD;
			operand   <= 32'h0000_0000;
			addr_mode <= MODE_COMPACT;
			trap_flags <= RST_FLAGS;
			trap_pc   <= RST_PC;
		end else if (wr_ok) begin
			unique case (paddr)
				OFS_INSTR:    instr     <= pwdata[15:0];
				OFS_OPERAND:  operand   <= pwdata;
				OFS_MODE:     addr_mode <= pwdata[1:0];
				OFS_TRAP_FLAGS: trap_flags <= pwdata[15:0];
				OFS_TRAP_PC:  trap_pc   <= pwdata;
				default: ;
			endcase
		end
	end

	// Flags; operand itself is never written by the test
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_control_word <= RST_FLAGS;
		end else if (wr_ok && paddr == OFS_FLAGS) begin
			flag_control_word <= pwdata[15:0];
		end else if (state == S_EXEC && is_zcmp && !bad_ptr) begin
			flag_control_word[FLAG_C] <= 1'b0;
			flag_control_word[FLAG_V] <= 1'b0;
			flag_control_word[FLAG_Z] <= (masked == 32'h0000_0000);
			flag_control_word[FLAG_S] <= neg;
		end else if (state == S_LOAD_STATUS) begin
			flag_control_word <= trap_flags;
		end
	end

	// Stack pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_stack_pointer <= RST_STACK;
		end else if (wr_ok && paddr == OFS_STACK) begin
			system_stack_pointer <= pwdata;
		end else if (state == S_PUSH_STATUS) begin
			system_stack_pointer <= system_stack_pointer - STATUS_BYTES;
		end else if (state == S_PUSH_INSTR) begin
			system_stack_pointer <= system_stack_pointer - INSTR_BYTES;
		end
	end

	// Program counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= RST_PC;
		end else if (wr_ok && paddr == OFS_PC) begin
			pc <= pwdata;
		end else if (state == S_EXEC && !(is_trap && cond_ok)) begin
			// Skip over the opcode word and any extension words
			pc <= pc + INSTR_BYTES + {29'h0, ext_words, 1'b0};
		end else if (state == S_LOAD_STATUS) begin
			pc <= trap_pc;
		end
	end

	// Stack write port; the status image is flag word above program counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_we     <= 1'b0;
			stack_addr   <= 32'h0000_0000;
			stack_wdata  <= 48'h0000_0000_0000;
			stack_nbytes <= 3'h0;
		end else begin
			stack_we <= 1'b0;
			if (state == S_PUSH_STATUS) begin
				stack_we     <= 1'b1;
				stack_addr   <= system_stack_pointer - STATUS_BYTES;
				stack_wdata  <= {flag_control_word, pc};
				stack_nbytes <= STATUS_BYTES[2:0];
			end else if (state == S_PUSH_INSTR) begin
				stack_we     <= 1'b1;
				stack_addr   <= system_stack_pointer - INSTR_BYTES;
				stack_wdata  <= {32'h0000_0000, instr};
				stack_nbytes <= INSTR_BYTES[2:0];
			end
		end
	end

	// Trap event, cause and indirect pointer reporting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_event <= 1'b0;
			trap_cause <= 4'h0;
			ptr_reg    <= 4'h0;
			ptr_long   <= 1'b0;
		end else begin
			trap_event <= (state == S_EXEC) && is_trap && cond_ok;
			if (state == S_EXEC && is_trap && cond_ok) begin
				trap_cause <= instr[7:4];
			end
			if (state == S_EXEC && is_zcmp && form_ir && !bad_ptr) begin
				ptr_reg  <= instr[7:4];
				ptr_long <= (addr_mode != MODE_COMPACT);
			end
		end
	end

	// Sticky status of the last executed instruction, cleared by the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_trapped   <= 1'b0;
			st_illegal   <= 1'b0;
			st_test_done <= 1'b0;
			st_ext       <= 2'h0;
		end else if (state == S_EXEC) begin
			st_trapped   <= is_trap & cond_ok;
			st_illegal   <= bad_ptr | ~(is_zcmp | is_trap);
			st_test_done <= is_zcmp & ~bad_ptr;
			st_ext       <= ext_words;
		end
	end

	// Slave answers one cycle into the access phase; unmapped or busy writes fail
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready
				& (~mapped | (pwrite & (state != S_IDLE || paddr == OFS_STATUS)));
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready && !pwrite) begin
				unique case (paddr)
					OFS_INSTR:    prdata <= {16'h0000, instr};
					OFS_OPERAND:  prdata <= operand;
					OFS_FLAGS:    prdata <= {16'h0000, flag_control_word};
					OFS_STACK:    prdata <= system_stack_pointer;
					OFS_MODE:     prdata <= {30'h0, addr_mode};
					OFS_PC:       prdata <= pc;
					OFS_TRAP_FLAGS: prdata <= {16'h0000, trap_flags};
					OFS_TRAP_PC:  prdata <= trap_pc;
					OFS_STATUS:   prdata <= {21'h0, ptr_long, st_ext, trap_cause,
						st_test_done, st_illegal, st_trapped, state != S_IDLE};
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// ==== tb/tarith_assertions.sv ====
`timescale 1ns/1ps
module tarith_chk (
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		stack_we,
	input wire logic [31:0]	stack_addr,
	input wire logic [2:0]	stack_nbytes,
	input wire logic		trap_event,
	input wire logic [3:0]	trap_cause
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Bus answers after exactly one wait state, for one cycle
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	// Taken trap pushes status first, then the word two bytes lower
	a_ps_push: assert property (trap_event |=> stack_we && stack_nbytes == 3'd6)
		else $error("status push missing");
	a_word_push: assert property (stack_we && stack_nbytes == 3'd6 |=> stack_we
		&& stack_nbytes == 3'd2 && stack_addr == $past(stack_addr) - 32'h2)
		else $error("word push wrong");
	// Stores only follow a taken trap
	a_push_cause: assert property ($rose(stack_we) |-> $past(trap_event))
		else $error("stray store");
	a_cause_hold: assert property ($changed(trap_cause) |-> trap_event)
		else $error("cause moved");
	a_trap_once: assert property (trap_event |=> !trap_event [*3])
		else $error("trap repeated");
	cover property (trap_event);
	cover property (pslverr);
	cover property (pready && psel && !pslverr);
endmodule

bind test_arith_and_cond_trap tarith_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .stack_we, .stack_addr, .stack_nbytes, .trap_event, .trap_cause);

// ==== tb/test_arith_and_cond_trap_tb_top.sv ====
`timescale 1ns/1ps
module test_arith_and_cond_trap_tb_top;
	import tarith_pkg::*;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic		stack_we, trap_event, ptr_long, ev;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata, stack_addr, rv, p, s;
	logic [47:0]	stack_wdata;
	logic [2:0]	stack_nbytes;
	logic [3:0]	trap_cause, ptr_reg;
	logic [82:0]	sq[$];
	int		errors, comparisons, traps;

	test_arith_and_cond_trap DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .stack_we, .stack_addr, .stack_wdata, .stack_nbytes,
		.trap_event, .trap_cause, .ptr_reg, .ptr_long);

	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end

	// Log stores and trap pulses as sampled at each edge
	always @(posedge pclk) begin
		if (stack_we === 1'b1)
			sq.push_back({stack_addr, stack_wdata, stack_nbytes});
		if (trap_event === 1'b1)
			traps++;
	end

	task finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string n, input logic [82:0] g, input logic [82:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Idle edge first, so a signal is never driven twice in one step
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			errors++;
			finish_test;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	// Start an instruction and poll status until idle
	task run(input logic [15:0] i);
		int k;
		k = 0;
		wr(OFS_INSTR, {16'h0, i});
		do begin
			rd(OFS_STATUS);
			k++;
		end while (rv[ST_BUSY] !== 1'b0 && k < 20);
		if (k >= 20) begin
			errors++;
			finish_test;
		end
	endtask

	task t_reset;
		rd(OFS_STATUS);
		chk("status", rv, 0);
		rd(8'h24);
		chk("unmapped", {ev, rv}, {1'b1, 32'h0});
		wr(OFS_STATUS, 32'h1);
		chk("ro", ev, 1);
	endtask

	// C, Z, V, D, H preset so cleared and kept flags both show
	task t_test;
		static logic [15:0] ti[5] = '{16'h8c3c, 16'h8d3c, 16'h9c3c, 16'h8d3c, 16'h4d2c};
		static logic [31:0] op[5] = '{32'h180, 32'h10000, 32'h80000000, 32'h7fff, 32'h0};
		static logic [7:0] ef[5] = '{8'h2c, 8'h4c, 8'h2c, 8'h0c, 8'h4c};
		static logic [3:0] pd[5] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h6};
		for (int j = 0; j < 5; j++) begin
			wr(OFS_FLAGS, 32'hdc);
			wr(OFS_OPERAND, op[j]);
			rd(OFS_PC);
			p = rv;
			run(ti[j]);
			chk("done", rv[ST_TEST_DONE], 1);
			rd(OFS_FLAGS);
			chk("flags", rv, ef[j]);
			rd(OFS_OPERAND);
			chk("operand", rv, op[j]);
			rd(OFS_PC);
			chk("pc", rv, p + pd[j]);
		end
	endtask

	task t_ptr;
		wr(OFS_MODE, {30'h0, MODE_LINEAR});
		run(16'h0d5c);
		chk("ptr", {ptr_long, ptr_reg}, 5'h15);
		wr(OFS_MODE, {30'h0, MODE_COMPACT});
		run(16'h0d6c);
		chk("ptr", {ptr_long, ptr_reg}, 5'h06);
		// Segmented mode must widen the pointer just like linear mode
		wr(OFS_MODE, {30'h0, MODE_SEGMENTED});
		run(16'h0d7c);
		chk("ptr", {ptr_long, ptr_reg}, 5'h17);
		chk("status ptr", rv[ST_PTR_LONG], 1);
		wr(OFS_FLAGS, 32'hdc);
		run(16'h0d0c);
		chk("illegal", rv[ST_ILLEGAL], 1);
		rd(OFS_FLAGS);
		chk("kept", rv, 32'hdc);
	endtask

	// Flags all clear, then C, Z, S and V all set; each mask lists the codes that trap
	task t_loop;
		logic [15:0] f;
		logic [15:0] m;
		logic e;
		wr(OFS_TRAP_FLAGS, 32'h10);
		wr(OFS_TRAP_PC, 32'h40);
		wr(OFS_STACK, 32'h1000);
		for (int g = 0; g < 2; g++) begin
			f = g ? 16'h00f0 : 16'h0000;
			m = g ? 16'h03fc : 16'hff00;
			for (int c = 0; c < 16; c++) begin
				e = m[c];
				wr(OFS_FLAGS, {16'h0, f});
				rd(OFS_STACK);
				s = rv;
				rd(OFS_PC);
				p = rv;
				traps = 0;
				run({TRAP_OPCODE, 4'h0, c[3:0]});
				chk("taken", traps, e);
				chk("trapped", rv[ST_TRAPPED], e);
				rd(OFS_STACK);
				chk("stack pointer", rv, e ? s - 8 : s);
				rd(OFS_FLAGS);
				chk("flag word", rv, e ? 32'h10 : {16'h0, f});
				rd(OFS_PC);
				chk("pc", rv, e ? 32'h40 : p + 2);
			end
		end
	endtask

	task t_push;
		wr(OFS_STACK, 32'h1000);
		wr(OFS_FLAGS, 32'h40);
		wr(OFS_PC, 32'h200);
		sq.delete();
		run(16'h7ef6);
		chk("pushes", sq.size(), 2);
		chk("status push", sq[0], {32'hffa, 16'h40, 32'h200, 3'd6});
		chk("word push", sq[1], {32'hff8, 32'h0, 16'h7ef6, 3'd2});
		chk("status cause", rv[ST_CAUSE_LSB +: 4], 4'hf);
		chk("cause", trap_cause, 4'hf);
	endtask

	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_test;
		t_ptr;
		t_loop;
		t_push;
		finish_test;
	end
endmodule
